// >>> design/oipr_top.sv
`timescale 1ns/1ps
// Range flag, init status and power profile registers behind the serial port
module oipr_top (
  input wire logic CLK_SYS_IN,
  input wire logic SRST_IN,
  input wire logic SPI_SCLK_IN,
  input wire logic SPI_CS_N_IN,
  input wire logic SPI_SDI_IN,
  output logic SPI_SDO_OUT,
  output logic SPI_SDO_OE_OUT,
  input wire logic SAMPLE_VALID_IN,
  input wire logic [3:0][11:0] SAMPLE_IN,
  output logic RANGE_FLAG_OUT_A_OUT,
  output logic RANGE_FLAG_OUT_B_OUT,
  output logic RANGE_FLAG_OUT_C_OUT,
  output logic RANGE_FLAG_OUT_D_OUT,
  output logic [7:0] PROFILE_CODE_SECOND_OUT,
  output logic [7:0] PROFILE_CODE_THIRD_OUT,
  output logic [7:0] PROFILE_CODE_FOURTH_OUT,
  output logic LOW_POWER_ACTIVE_OUT,
  output logic INIT_DONE_OUT
);

  // Pin synchronisers: index 0 clock, 1 select, 2 data
  logic [2:0] pin_meta_q;
  logic [2:0] pin_sync_q;
  logic sclk_prev_q;
  logic sclk_rise;
  logic sclk_fall;
  logic cs_active;
  logic sdi_bit;

  // Frame state
  logic [4:0] bit_cnt_q;
  logic frame_done_q;
  logic [22:0] shift_q;
  oipr_pkg::oipr_cmd_t cmd_q;
  oipr_pkg::oipr_cmd_t hdr_now;
  logic [7:0] rd_shift_q;
  logic rd_active_q;
  logic sdo_q;
  logic sdo_oe_q;

  // Write strobe formed on the last data bit
  logic wr_stb;
  logic [7:0] wr_data;

  // Register file
  logic [7:0] threshold_q;
  oipr_pkg::oipr_range_cfg_t range_cfg_q;
  logic [7:0] profile_second_q;
  logic [7:0] profile_third_q;
  logic [7:0] profile_fourth_q;
  logic soft_rst_q;
  logic blk_rst;
  logic [7:0] rd_data;

  // Status and outputs
  logic init_done;
  logic [3:0] chan_flag;
  logic [3:0] range_flag_q;
  logic [7:0] prof2_out_q;
  logic [7:0] prof3_out_q;
  logic [7:0] prof4_out_q;
  logic low_power_q;
  logic init_done_q;

  // Soft reset behaves like a power-on reset for the registers, timer and flag and profile pins; the serial port logic resets only on SRST_IN
  assign blk_rst = SRST_IN | soft_rst_q;

  // Two flops on every serial port pin before any logic looks at it; select resets idle high
  always_ff @(posedge CLK_SYS_IN) begin
    if (SRST_IN) begin
      pin_meta_q <= 3'h2;
      pin_sync_q <= 3'h2;
    end else begin
      pin_meta_q <= {SPI_SDI_IN, SPI_CS_N_IN, SPI_SCLK_IN};
      pin_sync_q <= pin_meta_q;
    end
  end

  // Last serial clock level; resets to the idle low level so no false edge follows
  always_ff @(posedge CLK_SYS_IN) begin
    if (SRST_IN) begin
      sclk_prev_q <= 1'b0;
    end else begin
      sclk_prev_q <= pin_sync_q[0];
    end
  end

  // Edges of the serial clock, seen through the synchroniser
  always_comb begin
    cs_active = !pin_sync_q[1];
    sdi_bit = pin_sync_q[2];
    sclk_rise = cs_active && pin_sync_q[0] && !sclk_prev_q;
    sclk_fall = cs_active && !pin_sync_q[0] && sclk_prev_q;
    hdr_now = {shift_q[14:0], sdi_bit};
    wr_data = {shift_q[6:0], sdi_bit};
    wr_stb = sclk_rise && (bit_cnt_q == oipr_pkg::FRAME_LAST_BIT) && !cmd_q.rd &&
      !frame_done_q;
  end

  // Shift register and bit counter; deselect aborts a partial frame
  always_ff @(posedge CLK_SYS_IN) begin
    if (SRST_IN || !cs_active) begin
      bit_cnt_q <= '0;
      shift_q <= '0;
    end else if (sclk_rise) begin
      shift_q <= {shift_q[21:0], sdi_bit};
      if (bit_cnt_q != oipr_pkg::FRAME_LAST_BIT) begin
        bit_cnt_q <= bit_cnt_q + 5'h01;
      end
    end
  end

  // Frame end marker: bits after the twenty-fourth are ignored, so a long frame
  // cannot commit the same write twice
  always_ff @(posedge CLK_SYS_IN) begin
    if (SRST_IN || !cs_active) begin
      frame_done_q <= 1'b0;
    end else if (sclk_rise && bit_cnt_q == oipr_pkg::FRAME_LAST_BIT) begin
      frame_done_q <= 1'b1;
    end
  end

  // Header latch: read flag and address after the sixteenth bit
  always_ff @(posedge CLK_SYS_IN) begin
    if (SRST_IN || !cs_active) begin
      cmd_q <= '0;
    end else if (sclk_rise && bit_cnt_q == oipr_pkg::HEADER_LAST_BIT) begin
      cmd_q <= hdr_now;
    end
  end

  // Read data mux; unmapped addresses read zero
  always_comb begin
    case (hdr_now.addr)
      oipr_pkg::ADDR_RANGE_THRESHOLD: rd_data = threshold_q;
      oipr_pkg::ADDR_RANGE_FLAG_CONFIG: rd_data = range_cfg_q;
      oipr_pkg::ADDR_INIT_DONE_STATUS: rd_data = {7'h00, init_done}; // see R6
      oipr_pkg::ADDR_POWER_PROFILE_SECOND: rd_data = profile_second_q;
      oipr_pkg::ADDR_POWER_PROFILE_THIRD: rd_data = profile_third_q;
      oipr_pkg::ADDR_POWER_PROFILE_FOURTH: rd_data = profile_fourth_q;
      default: rd_data = 8'h00;
    endcase
  end

  // Read shifter: first bit set up at header end, next ones on falling edges
  always_ff @(posedge CLK_SYS_IN) begin
    if (SRST_IN || !cs_active) begin
      rd_shift_q <= '0;
    end else if (sclk_rise && bit_cnt_q == oipr_pkg::HEADER_LAST_BIT) begin
      rd_shift_q <= rd_data;
    end else if (sclk_fall && bit_cnt_q >= oipr_pkg::FIRST_SHIFT_BIT) begin
      rd_shift_q <= {rd_shift_q[6:0], 1'b0};
    end
  end

  // Read flag of the current frame, held until deselect
  always_ff @(posedge CLK_SYS_IN) begin
    if (SRST_IN || !cs_active) begin
      rd_active_q <= 1'b0;
    end else if (sclk_rise && bit_cnt_q == oipr_pkg::HEADER_LAST_BIT) begin
      rd_active_q <= hdr_now.rd;
    end
  end

  // Data out pin comes straight from a flop
  always_ff @(posedge CLK_SYS_IN) begin
    if (SRST_IN) begin
      sdo_q <= 1'b0;
    end else begin
      sdo_q <= rd_shift_q[7];
    end
  end

  // Output enable only while a read frame owns the data phase
  always_ff @(posedge CLK_SYS_IN) begin
    if (SRST_IN) begin
      sdo_oe_q <= 1'b0;
    end else begin
      sdo_oe_q <= rd_active_q && cs_active && (bit_cnt_q >= oipr_pkg::HEADER_BITS);
    end
  end

  // Soft reset pulse; the host may issue it even before init is done
  always_ff @(posedge CLK_SYS_IN) begin
    if (SRST_IN) begin
      soft_rst_q <= 1'b0;
    end else begin
      soft_rst_q <= wr_stb && (cmd_q.addr == oipr_pkg::ADDR_CONTROL) &&
        wr_data[oipr_pkg::SOFT_RESET_BIT];
    end
  end

  // Threshold register
  always_ff @(posedge CLK_SYS_IN) begin
    if (blk_rst) begin
      threshold_q <= oipr_pkg::RST_RANGE_THRESHOLD; // see R15
    end else if (wr_stb && cmd_q.addr == oipr_pkg::ADDR_RANGE_THRESHOLD) begin
      threshold_q <= wr_data;
    end
  end

  // Flag config: reserved bits stored as written, host keeps them zero
  always_ff @(posedge CLK_SYS_IN) begin
    if (blk_rst) begin
      range_cfg_q.rsvd <= oipr_pkg::RST_CFG_RSVD;
      range_cfg_q.enable <= oipr_pkg::RST_FLAG_ENABLE; // see R4
      range_cfg_q.stretch_exp <= oipr_pkg::RST_STRETCH_EXP; // see R4
    end else if (wr_stb && cmd_q.addr == oipr_pkg::ADDR_RANGE_FLAG_CONFIG) begin
      range_cfg_q <= wr_data;
    end
  end

  // Power profile registers; reserved codes are stored but not decoded
  always_ff @(posedge CLK_SYS_IN) begin
    if (blk_rst) begin
      profile_second_q <= oipr_pkg::RST_PROFILE_SECOND; // see R8
      profile_third_q <= oipr_pkg::RST_PROFILE_THIRD; // see R9
      profile_fourth_q <= oipr_pkg::RST_PROFILE_FOURTH; // see R10
    end else if (wr_stb) begin
      if (cmd_q.addr == oipr_pkg::ADDR_POWER_PROFILE_SECOND) begin
        profile_second_q <= wr_data; // see R8
      end
      if (cmd_q.addr == oipr_pkg::ADDR_POWER_PROFILE_THIRD) begin
        profile_third_q <= wr_data; // see R9
      end
      if (cmd_q.addr == oipr_pkg::ADDR_POWER_PROFILE_FOURTH) begin
        profile_fourth_q <= wr_data; // see R10
      end
    end
  end

  // Profile codes to the analog core, one cycle behind the registers
  always_ff @(posedge CLK_SYS_IN) begin
    if (blk_rst) begin
      prof2_out_q <= oipr_pkg::RST_PROFILE_SECOND;
      prof3_out_q <= oipr_pkg::RST_PROFILE_THIRD;
      prof4_out_q <= oipr_pkg::RST_PROFILE_FOURTH;
    end else begin
      prof2_out_q <= profile_second_q;
      prof3_out_q <= profile_third_q;
      prof4_out_q <= profile_fourth_q;
    end
  end

  // Low-power summary; only a matched set counts, since the host writes them as a group
  always_ff @(posedge CLK_SYS_IN) begin
    if (blk_rst) begin
      low_power_q <= 1'b0;
    end else begin
      low_power_q <= (profile_second_q == oipr_pkg::LOW_CODE_SECOND) &&
        (profile_third_q == oipr_pkg::LOW_CODE_THIRD) &&
        (profile_fourth_q == oipr_pkg::LOW_CODE_FOURTH); // see R12
    end
  end

  // Initialization timer, restarted by soft reset
  oipr_init u_init (
    .clk_in(CLK_SYS_IN),
    .rst_in(blk_rst),
    .done_out(init_done)
  );

  // One detector per channel
  for (genvar ch = 0; ch < oipr_pkg::CHANNELS; ch++) begin : g_chan
    oipr_chan u_chan (
      .clk_in(CLK_SYS_IN),
      .rst_in(blk_rst),
      .sample_valid_in(SAMPLE_VALID_IN),
      .sample_in(SAMPLE_IN[ch]),
      .threshold_in(threshold_q),
      .stretch_exp_in(range_cfg_q.stretch_exp),
      .flag_out(chan_flag[ch])
    );
  end

  // Flag pins gated by the enable; detectors keep running while gated
  always_ff @(posedge CLK_SYS_IN) begin
    if (blk_rst) begin
      range_flag_q <= '0;
    end else if (range_cfg_q.enable) begin
      range_flag_q <= chan_flag; // see R2
    end else begin
      range_flag_q <= '0; // see R1
    end
  end

  // Init status pin
  always_ff @(posedge CLK_SYS_IN) begin
    if (blk_rst) begin
      init_done_q <= 1'b0;
    end else begin
      init_done_q <= init_done;
    end
  end

  assign SPI_SDO_OUT = sdo_q;
  assign SPI_SDO_OE_OUT = sdo_oe_q;
  assign RANGE_FLAG_OUT_A_OUT = range_flag_q[0];
  assign RANGE_FLAG_OUT_B_OUT = range_flag_q[1];
  assign RANGE_FLAG_OUT_C_OUT = range_flag_q[2];
  assign RANGE_FLAG_OUT_D_OUT = range_flag_q[3];
  assign PROFILE_CODE_SECOND_OUT = prof2_out_q;
  assign PROFILE_CODE_THIRD_OUT = prof3_out_q;
  assign PROFILE_CODE_FOURTH_OUT = prof4_out_q;
  assign LOW_POWER_ACTIVE_OUT = low_power_q;
  assign INIT_DONE_OUT = init_done_q;

endmodule

// >>> design/oipr_pkg.sv
// How it works
// R1: Flag outputs held low while enable clear
// R2: Enable set shows each channel's range status
// R3: Minimum flag width is 4 times 2^exponent
// R4: Exponent doubles period; resets 0x7, enable 0x0
// R5: Host writes zero to config bits 7:4
// R6: Init status bit 0 set when done
// R7: Host waits for init done, except reset
// R8: Second profile: 0x06 low, 0x0F high, reset 0x0F
// R9: Third profile: 0x00 low, 0x04 high, reset 0x04
// R10: Fourth profile: 0x14 low, 0x1B high, reset 0x1B
// R11: Low power only at up to 1 GSPS
// R12: Host programs all profile registers together
// R13: Host clears calibration and link enables first
// R14: Host recalibrates after a profile change
// R15: Flag asserts when level reaches threshold 0xF2
// R16: New detection restarts the stretch counter
package oipr_pkg;

  // Register offsets on the serial configuration port
  localparam logic [14:0] ADDR_CONTROL = 15'h0000;
  localparam logic [14:0] ADDR_RANGE_THRESHOLD = 15'h0211;
  localparam logic [14:0] ADDR_RANGE_FLAG_CONFIG = 15'h0213;
  localparam logic [14:0] ADDR_INIT_DONE_STATUS = 15'h0270;
  localparam logic [14:0] ADDR_POWER_PROFILE_SECOND = 15'h029A;
  localparam logic [14:0] ADDR_POWER_PROFILE_THIRD = 15'h029B;
  localparam logic [14:0] ADDR_POWER_PROFILE_FOURTH = 15'h029C;

  // Reset values
  localparam logic [7:0] RST_RANGE_THRESHOLD = 8'hF2;
  localparam logic [2:0] RST_STRETCH_EXP = 3'h7;
  localparam logic RST_FLAG_ENABLE = 1'h0;
  localparam logic [3:0] RST_CFG_RSVD = 4'h0;
  localparam logic [7:0] RST_PROFILE_SECOND = 8'h0F;
  localparam logic [7:0] RST_PROFILE_THIRD = 8'h04;
  localparam logic [7:0] RST_PROFILE_FOURTH = 8'h1B;

  // Profile codes
  localparam logic [7:0] LOW_CODE_SECOND = 8'h06;
  localparam logic [7:0] LOW_CODE_THIRD = 8'h00;
  localparam logic [7:0] LOW_CODE_FOURTH = 8'h14;

  // Soft reset bit in the control register
  localparam int SOFT_RESET_BIT = 7;

  // Serial frame layout: read flag, 15-bit address, 8-bit data
  localparam logic [4:0] FRAME_LAST_BIT = 5'h17;
  localparam logic [4:0] HEADER_LAST_BIT = 5'h0F;
  localparam logic [4:0] HEADER_BITS = 5'h10;
  localparam logic [4:0] FIRST_SHIFT_BIT = 5'h11;

  // Sample and level widths
  localparam int SAMPLE_W = 12;
  localparam int CHANNELS = 4;
  localparam logic [7:0] LEVEL_SATURATED = 8'hFF;

  // Range flag stretch: base 4 sampling cycles, counter wide enough for 4 * 2^7
  localparam int STRETCH_W = 10;
  localparam logic [STRETCH_W-1:0] STRETCH_BASE = 10'h004;

  // Initialization time after reset
  localparam int CLK_MHZ = 125;
  localparam int INIT_TIME_NS = 1000;
  localparam int INIT_CYCLES = (INIT_TIME_NS * CLK_MHZ + 999) / 1000;
  localparam int INIT_CNT_W = 8;

  // Range flag configuration field layout
  typedef struct packed {
    logic [3:0] rsvd;
    logic enable;
    logic [2:0] stretch_exp;
  } oipr_range_cfg_t;

  // Decoded serial command header
  typedef struct packed {
    logic rd;
    logic [14:0] addr;
  } oipr_cmd_t;

endpackage

// >>> design/oipr_chan.sv
`timescale 1ns/1ps
// Per-channel level detector with minimum-width pulse stretch
module oipr_chan (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic sample_valid_in,
  input wire logic [oipr_pkg::SAMPLE_W-1:0] sample_in,
  input wire logic [7:0] threshold_in,
  input wire logic [2:0] stretch_exp_in,
  output logic flag_out
);

  logic [oipr_pkg::SAMPLE_W-1:0] mag;
  logic [7:0] level;
  logic detect;
  logic [oipr_pkg::STRETCH_W-1:0] len;
  logic [oipr_pkg::STRETCH_W-1:0] cnt_q;
  logic flag_q;

  // Magnitude scaled so full scale maps onto the 8-bit threshold range
  always_comb begin
    mag = sample_in[oipr_pkg::SAMPLE_W-1] ? oipr_pkg::SAMPLE_W'(-sample_in) : sample_in;
    level = mag[oipr_pkg::SAMPLE_W-1] ? oipr_pkg::LEVEL_SATURATED : mag[10:3];
    detect = sample_valid_in && (level >= threshold_in); // see R15
    len = oipr_pkg::STRETCH_BASE << stretch_exp_in; // see R3 see R4
  end

  // Stretch counter counts sampling cycles, not system clocks
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      cnt_q <= '0;
      flag_q <= 1'b0;
    end else if (detect) begin
      cnt_q <= len - oipr_pkg::STRETCH_W'(1); // see R16
      flag_q <= 1'b1;
    end else if (sample_valid_in) begin
      if (cnt_q != '0) begin
        cnt_q <= cnt_q - oipr_pkg::STRETCH_W'(1);
      end else begin
        flag_q <= 1'b0;
      end
    end
  end

  assign flag_out = flag_q;

endmodule

// >>> design/oipr_init.sv
`timescale 1ns/1ps
// Initialization timer: done flag rises a fixed time after reset
module oipr_init (
  input wire logic clk_in,
  input wire logic rst_in,
  output logic done_out
);

  logic [oipr_pkg::INIT_CNT_W-1:0] cnt_q;
  logic done_q;

  // Count until the internal setup time has elapsed, then hold done
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      cnt_q <= '0;
      done_q <= 1'b0;
    end else if (!done_q) begin
      if (cnt_q == oipr_pkg::INIT_CNT_W'(oipr_pkg::INIT_CYCLES - 1)) begin
        done_q <= 1'b1; // see R6
      end
      cnt_q <= cnt_q + oipr_pkg::INIT_CNT_W'(1);
    end
  end

  assign done_out = done_q;

endmodule

// >>> testbench/oipr_chk.sv
`timescale 1ns/1ps
// Port-level checks on the range flag, init and profile slice
module oipr_chk (
  input wire logic CLK_SYS_IN,
  input wire logic SRST_IN,
  input wire logic SPI_CS_N_IN,
  input wire logic SPI_SDO_OE_OUT,
  input wire logic SAMPLE_VALID_IN,
  input wire logic RANGE_FLAG_OUT_A_OUT,
  input wire logic [7:0] PROFILE_CODE_SECOND_OUT,
  input wire logic [7:0] PROFILE_CODE_THIRD_OUT,
  input wire logic [7:0] PROFILE_CODE_FOURTH_OUT,
  input wire logic LOW_POWER_ACTIVE_OUT,
  input wire logic INIT_DONE_OUT
);
  default clocking @(posedge CLK_SYS_IN); endclocking
  default disable iff (SRST_IN);
  logic [7:0] up_q;
  // Cycles since reset release, saturating so it never wraps
  always_ff @(posedge CLK_SYS_IN) begin
    if (SRST_IN) up_q <= 8'h00;
    else if (up_q != 8'hFF) up_q <= up_q + 8'h01;
  end
  a_reset_quiet: assert property (disable iff (1'b0) SRST_IN |=>
    !RANGE_FLAG_OUT_A_OUT && !SPI_SDO_OE_OUT && !INIT_DONE_OUT) else $error("flag after reset");
  a_reset_profile: assert property (disable iff (1'b0) SRST_IN |=>
    PROFILE_CODE_SECOND_OUT == 8'h0F && PROFILE_CODE_THIRD_OUT == 8'h04
    && PROFILE_CODE_FOURTH_OUT == 8'h1B) else $error("profile reset value");
  a_power_match: assert property (LOW_POWER_ACTIVE_OUT ==
    (PROFILE_CODE_SECOND_OUT == 8'h06 && PROFILE_CODE_THIRD_OUT == 8'h00
    && PROFILE_CODE_FOURTH_OUT == 8'h14)) else $error("low power flag wrong");
  a_init_early: assert property ($rose(INIT_DONE_OUT) |-> up_q >= 8'h7D)
    else $error("init done too early");
  a_init_late: assert property (up_q == 8'h90 |-> INIT_DONE_OUT)
    else $error("init done too late");
  a_init_stays: assert property (INIT_DONE_OUT && SPI_CS_N_IN |=> INIT_DONE_OUT)
    else $error("init done dropped");
  a_flag_width: assert property ($rose(RANGE_FLAG_OUT_A_OUT) |=>
    RANGE_FLAG_OUT_A_OUT [*3]) else $error("flag pulse short");
  a_flag_cause: assert property ($rose(RANGE_FLAG_OUT_A_OUT) |->
    $past(SAMPLE_VALID_IN, 2)) else $error("flag without sample");
  a_profile_frame: assert property ($changed(PROFILE_CODE_SECOND_OUT) |->
    !$past(SPI_CS_N_IN, 2)) else $error("profile changed outside frame");
  cover property ($rose(RANGE_FLAG_OUT_A_OUT));
  cover property ($rose(LOW_POWER_ACTIVE_OUT));
  cover property ($rose(SPI_SDO_OE_OUT));
  cover property ($fell(INIT_DONE_OUT));
endmodule
bind oipr_top oipr_chk u_chk (.CLK_SYS_IN(CLK_SYS_IN), .SRST_IN(SRST_IN),
  .SPI_CS_N_IN(SPI_CS_N_IN), .SPI_SDO_OE_OUT(SPI_SDO_OE_OUT),
  .SAMPLE_VALID_IN(SAMPLE_VALID_IN), .RANGE_FLAG_OUT_A_OUT(RANGE_FLAG_OUT_A_OUT),
  .PROFILE_CODE_SECOND_OUT(PROFILE_CODE_SECOND_OUT),
  .PROFILE_CODE_THIRD_OUT(PROFILE_CODE_THIRD_OUT),
  .PROFILE_CODE_FOURTH_OUT(PROFILE_CODE_FOURTH_OUT),
  .LOW_POWER_ACTIVE_OUT(LOW_POWER_ACTIVE_OUT), .INIT_DONE_OUT(INIT_DONE_OUT));

// >>> testbench/oipr_host_model.sv
`timescale 1ns/1ps
// Host on the serial port; each frame is one blocking task call
module oipr_host_model (
  input wire logic clk_in,
  input wire logic init_done_in,
  input wire logic sdo_in,
  input wire logic sdo_oe_in,
  output logic sclk_out,
  output logic cs_n_out,
  output logic sdi_out
);
  int timeouts = 0;
  initial begin
    sclk_out = 1'b0;
    cs_n_out = 1'b1;
    sdi_out = 1'b0;
  end
  task automatic tick(input int n);
    repeat (n) @(posedge clk_in);
  endtask
  // Half period h in clocks: 4 is the fastest legal host, 8 a slow one
  task automatic xfer(input logic rd, input logic [14:0] a, input logic [7:0] wd,
    input int h, output logic [7:0] rdat);
    logic [23:0] fr;
    int w;
    fr = {rd, a, wd};
    rdat = 8'h00;
    w = 0;
    // Only soft reset may go ahead of init done; this task still waits for init done on every frame, soft reset included
    while (!init_done_in && w < 400) begin
      tick(1);
      w++;
    end
    if (w >= 400) timeouts++;
    @(posedge clk_in);
    cs_n_out <= 1'b0;
    for (int i = 23; i >= 0; i--) begin
      tick(h / 2);
      sdi_out <= fr[i];
      tick(h - h / 2);
      if (i < 8) rdat[i] = sdo_oe_in ? sdo_in : 1'bx;
      sclk_out <= 1'b1;
      tick(h);
      sclk_out <= 1'b0;
    end
    tick(h);
    cs_n_out <= 1'b1;
    // A released data line must not look held
    sdi_out <= ~fr[0];
    tick(6);
  endtask
endmodule

// >>> testbench/overrange_init_power_regs_tb_top.sv
`timescale 1ns/1ps
`define CHK(nm, ex, gt) begin checks_done++; if ((gt) !== (ex)) begin errors++; \
  $display("wrong value %s expected %0h seen %0h", nm, ex, gt); end end
module overrange_init_power_regs_tb_top;
  logic clk = 1'b0;
  logic srst = 1'b1;
  logic valid = 1'b0;
  logic sclk, cs_n, sdi, sdo, sdo_oe, lp, done;
  logic [3:0][11:0] samp = '0;
  logic [3:0] flg;
  logic [7:0] pc2, pc3, pc4, rv;
  int errors = 0;
  int checks_done = 0;
  int ca = 0;
  int cb = 0;
  int n, na, nb;
  always #4 clk = ~clk;
  // Running totals of flag cycles not low, so an unknown counts too
  always @(posedge clk) begin
    ca <= ca + int'(flg[0] !== 1'b0);
    cb <= cb + int'(flg[3:1] !== 3'h0);
  end
  oipr_top DUT (.CLK_SYS_IN(clk), .SRST_IN(srst), .SPI_SCLK_IN(sclk), .SPI_CS_N_IN(cs_n),
    .SPI_SDI_IN(sdi), .SPI_SDO_OUT(sdo), .SPI_SDO_OE_OUT(sdo_oe), .SAMPLE_VALID_IN(valid),
    .SAMPLE_IN(samp), .RANGE_FLAG_OUT_A_OUT(flg[0]), .RANGE_FLAG_OUT_B_OUT(flg[1]),
    .RANGE_FLAG_OUT_C_OUT(flg[2]), .RANGE_FLAG_OUT_D_OUT(flg[3]),
    .PROFILE_CODE_SECOND_OUT(pc2), .PROFILE_CODE_THIRD_OUT(pc3),
    .PROFILE_CODE_FOURTH_OUT(pc4), .LOW_POWER_ACTIVE_OUT(lp), .INIT_DONE_OUT(done));
  oipr_host_model host (.clk_in(clk), .init_done_in(done), .sdo_in(sdo),
    .sdo_oe_in(sdo_oe), .sclk_out(sclk), .cs_n_out(cs_n), .sdi_out(sdi));
  task automatic wrap_up();
    errors += host.timeouts;
    if (errors == 0 && checks_done > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  task automatic wr(input logic [14:0] a, input logic [7:0] d);
    host.xfer(1'b0, a, d, 4, rv);
  endtask
  task automatic rdc(input logic [14:0] a, input logic [7:0] ex);
    host.xfer(1'b1, a, 8'h00, 8, rv);
    `CHK($sformatf("reg %h", a), ex, rv)
  endtask
  // Hit channel A once, or twice gap cycles apart, then count flag cycles
  task automatic hits(input logic [11:0] s, input int gap);
    int a0, b0;
    a0 = ca;
    b0 = cb;
    for (int k = 0; k < (gap > 0 ? 2 : 1); k++) begin
      @(posedge clk);
      samp[0] <= s;
      @(posedge clk);
      samp[0] <= 12'h000;
      repeat (gap - 2) @(posedge clk);
    end
    repeat (70) @(posedge clk);
    #1;
    na = ca - a0;
    nb = cb - b0;
  endtask
  initial begin
    repeat (5) @(posedge clk);
    srst <= 1'b0;
    @(posedge clk);
    #1;
    `CHK("init early", 1'b0, done)
    n = 0;
    while (done !== 1'b1 && n < 300) begin
      @(posedge clk);
      n++;
    end
    if (n >= 300) begin
      errors++;
      wrap_up();
    end
    rdc(oipr_pkg::ADDR_INIT_DONE_STATUS, 8'h01);
    wr(oipr_pkg::ADDR_INIT_DONE_STATUS, 8'hFE);
    rdc(oipr_pkg::ADDR_INIT_DONE_STATUS, 8'h01);
    rdc(oipr_pkg::ADDR_RANGE_FLAG_CONFIG, 8'h07);
    rdc(oipr_pkg::ADDR_RANGE_THRESHOLD, 8'hF2);
    rdc(oipr_pkg::ADDR_POWER_PROFILE_SECOND, 8'h0F);
    rdc(oipr_pkg::ADDR_POWER_PROFILE_THIRD, 8'h04);
    rdc(oipr_pkg::ADDR_POWER_PROFILE_FOURTH, 8'h1B);
    rdc(15'h0300, 8'h00);
    valid <= 1'b1;
    // Short stretch first, so enabling later shows no leftover pulse
    wr(oipr_pkg::ADDR_RANGE_FLAG_CONFIG, 8'h00);
    hits(12'h790, 0);
    `CHK("flag while off", 0, na)
    for (int e = 0; e < 3; e++) begin
      wr(oipr_pkg::ADDR_RANGE_FLAG_CONFIG, {4'h0, 1'b1, 3'(e)});
      hits(12'h790, 0);
      `CHK("flag width", 1'b1, na >= (4 << e) && na <= (4 << e) + 1)
      `CHK("other flags", 0, nb)
    end
    wr(oipr_pkg::ADDR_RANGE_FLAG_CONFIG, 8'h08);
    hits(12'h788, 0);
    `CHK("below level", 0, na)
    hits(12'h870, 0);
    `CHK("negative level", 1'b1, na >= 4 && na <= 5)
    hits(12'h790, 3);
    `CHK("restart", 1'b1, na >= 7 && na <= 8)
    // Every other channel raises its own pin and no other
    for (int c = 1; c < 4; c++) begin
      @(posedge clk);
      samp[c] <= 12'h790;
      @(posedge clk);
      samp[c] <= 12'h000;
      repeat (2) @(posedge clk);
      #1;
      `CHK("channel pin", 4'(1 << c), flg)
      repeat (10) @(posedge clk);
    end
    // Calibration and link enables live outside and stay off
    // Low power stands for a rate at or below 1 GSPS
    for (int m = 0; m < 2; m++) begin
      wr(oipr_pkg::ADDR_POWER_PROFILE_SECOND, m ? 8'h0F : 8'h06);
      `CHK("partial set", 1'b0, lp)
      wr(oipr_pkg::ADDR_POWER_PROFILE_THIRD, m ? 8'h04 : 8'h00);
      wr(oipr_pkg::ADDR_POWER_PROFILE_FOURTH, m ? 8'h1B : 8'h14);
      `CHK("low power", m ? 1'b0 : 1'b1, lp)
      `CHK("code two", m ? 8'h0F : 8'h06, pc2)
      `CHK("code three", m ? 8'h04 : 8'h00, pc3)
      `CHK("code four", m ? 8'h1B : 8'h14, pc4)
      rdc(oipr_pkg::ADDR_POWER_PROFILE_FOURTH, m ? 8'h1B : 8'h14);
    end
    // A fresh calibration follows a profile change, outside this slice
    // Soft reset puts back every default and restarts initialization
    wr(oipr_pkg::ADDR_RANGE_THRESHOLD, 8'h10);
    wr(oipr_pkg::ADDR_RANGE_FLAG_CONFIG, 8'h0B);
    wr(oipr_pkg::ADDR_POWER_PROFILE_SECOND, 8'h06);
    wr(oipr_pkg::ADDR_POWER_PROFILE_THIRD, 8'h00);
    wr(oipr_pkg::ADDR_POWER_PROFILE_FOURTH, 8'h14);
    `CHK("low power before soft reset", 1'b1, lp)
    wr(oipr_pkg::ADDR_CONTROL, 8'h80);
    `CHK("init after soft reset", 1'b0, done)
    `CHK("low power after soft reset", 1'b0, lp)
    `CHK("code two after soft reset", 8'h0F, pc2)
    rdc(oipr_pkg::ADDR_RANGE_FLAG_CONFIG, 8'h07);
    rdc(oipr_pkg::ADDR_RANGE_THRESHOLD, 8'hF2);
    rdc(oipr_pkg::ADDR_CONTROL, 8'h00);
    wrap_up();
  end
endmodule
